/* rtl/smc_pkg.sv */
// Package: constants, types and field layout of the motion command decoder
// ==========================================================================
// Behaviour
// (R1) Driver enable gates motor current; config error refuses
// (R2) Master keeps reserved option bits at zero
// (R3) Preset from parameter or scaled encoder position
// (R4) Position preset clears move-complete and position-invalid
// (R5) Proximity bit gates the home input
// (R6) Run assembled: blend or dwell by bit
// (R7) Dwell move uses dwell time word
// (R8) Blend direction bit selects clockwise or counter-clockwise
// (R9) Indexed bit defers move to start input
// (R10) Master holds image during indexed move
// (R11) Jog or registration move by bit
// (R12) Program-assembled fall with persist bit stores move
// (R13) Flash result blinks LED, then lockout
// (R14) Encoder preset with persist bit stores offset
// (R15) Current from default or parameter word
// (R16) Current update alone or with moves
// (R17) Absolute move code, 24-bit signed target
// (R18) Relative move code, 24-bit signed distance
// (R19) Master keeps parameters within limits
// (R20) Hold ignores all parameter words
// (R21) Resume keeps original target position
// (R22) Unused parameter words never cause errors
// (R23) Commands act on rising bits, program-assembled on its falling bit
// (R24) Master raises one request bit per update
// (R25) Run-assembled edge starts stored move
// (R26) Hold decelerates, move stays resumable
// (R27) Parameters sampled with the command edge
package smc_pkg;

  // ========================================================================
  // Request word bit positions
  localparam int REQ_ABSOLUTE = 0;
  localparam int REQ_RELATIVE = 1;
  localparam int REQ_HOLD = 2;
  localparam int REQ_RESUME = 3;
  localparam int REQ_JOG_CW = 7;
  localparam int REQ_JOG_CCW = 8;
  localparam int REQ_PRESET_POS = 9;
  localparam int REQ_PROGRAM_ASM = 12;
  localparam int REQ_RUN_ASM = 13;
  localparam int REQ_PRESET_ENC = 14;

  // ========================================================================
  // Option word bit positions
  localparam int OPT_CURRENT_SEL = 1;
  localparam int OPT_BLEND_CCW = 4;
  localparam int OPT_PERSIST = 5;
  localparam int OPT_REGISTRATION = 7;
  localparam int OPT_INDEXED = 8;
  localparam int OPT_DWELL = 9;
  localparam int OPT_PROX_GATE = 11;
  localparam int OPT_PRESET_FEEDBACK = 13;
  localparam int OPT_DRIVER_ENABLE = 15;
  localparam logic [15:0] OPT_RESERVED_MASK = 16'h544D;

  // ========================================================================
  // Parameter limits
  localparam logic signed [31:0] POS_MIN = -32'sd8388608;
  localparam logic signed [31:0] POS_MAX = 32'sd8388607;
  localparam logic [31:0] SPEED_MAX = 32'h002D_C6BF;
  localparam logic [15:0] RATE_MIN = 16'h0001;
  localparam logic [15:0] RATE_MAX = 16'h1388;
  localparam logic [15:0] CURRENT_MAX = 16'h0036;

  // ========================================================================
  // Timing
  localparam int CLK_HZ = 125000000;
  localparam int LED_FAST_HZ = 4;
  localparam int LED_SLOW_HZ = 1;
  localparam int LED_FAST_HALF = CLK_HZ / (2 * LED_FAST_HZ);
  localparam int LED_SLOW_HALF = CLK_HZ / (2 * LED_SLOW_HZ);
  localparam int DIV_STEPS = 48;

  // ========================================================================
  // Types
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARMED = 5'h02,
    ST_DIVIDE = 5'h04,
    ST_FLASH = 5'h08,
    ST_LOCKED = 5'h10
  } smc_state_type;

  typedef enum logic [5:0] {
    MV_NONE = 6'h00,
    MV_ABSOLUTE = 6'h01,
    MV_RELATIVE = 6'h02,
    MV_JOG = 6'h04,
    MV_REGISTRATION = 6'h08,
    MV_BLEND = 6'h10,
    MV_DWELL = 6'h20
  } smc_move_type;

  typedef struct packed {
    logic [31:0] position;
    logic [31:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] current;
    logic [15:0] jerk;
    logic [15:0] dwell;
  } smc_params_type;

endpackage

/* rtl/smc_param_if.sv */
// Interface: parameter words between decoder and parameter store
`timescale 1ns/1ps
interface smc_param_if;
  smc_pkg::smc_params_type raw;
  smc_pkg::smc_params_type held;
  logic cap_all;
  logic cap_target;
  modport ctrl (output raw, output cap_all, output cap_target, input held);
  modport store (input raw, input cap_all, input cap_target, output held);
endinterface

/* rtl/smc_param_store.sv */
// Module: parameter set captured at the accepted command edge
`timescale 1ns/1ps
module smc_param_store (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  smc_param_if.store prm // Raw words in, held set out
);

  // ========================================================================
  // Capture; target kept apart so a resume cannot move it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prm.held <= '0;
    end else begin
      if (prm.cap_all) begin // (R27)
        prm.held.speed <= prm.raw.speed;
        prm.held.accel <= prm.raw.accel;
        prm.held.decel <= prm.raw.decel;
        prm.held.current <= prm.raw.current;
        prm.held.jerk <= prm.raw.jerk;
        prm.held.dwell <= prm.raw.dwell;
      end
      if (prm.cap_target) begin // (R21)
        prm.held.position <= prm.raw.position;
      end
    end
  end

endmodule // smc_param_store

/* rtl/smc_decoder.sv */
// Module: command image decoder of the stepper indexer
`timescale 1ns/1ps
module smc_decoder #(
  parameter int FAST_HALF_CYCLES = smc_pkg::LED_FAST_HALF,
  parameter int SLOW_HALF_CYCLES = smc_pkg::LED_SLOW_HALF
) (
  input wire logic core_clk, // System clock, 125 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic image_valid, // Pulse: new output image present
  input wire logic [15:0] command_request_word, // Request bits
  input wire logic [15:0] command_option_word, // Option bits
  input wire logic [31:0] target_position, // Signed position word
  input wire logic [31:0] programmed_speed, // Speed word
  input wire logic [15:0] accel_rate, // Acceleration word
  input wire logic [15:0] decel_rate, // Deceleration word
  input wire logic [15:0] drive_amps_setting, // Motor current word
  input wire logic [15:0] accel_jerk, // Jerk word
  input wire logic [15:0] dwell_time, // Dwell time word, ms
  input wire logic config_error, // Configuration error present
  input wire logic use_prox_gate, // Home proximity gate configured
  input wire logic home_in, // Home input level
  input wire logic start_in, // Indexer start input level
  input wire logic move_active, // Motion generator busy
  input wire logic [31:0] encoder_position, // Signed encoder position
  input wire logic [15:0] motor_steps_per_turn, // Motor steps per turn
  input wire logic [15:0] encoder_pulses_per_turn, // Encoder pulses per turn
  input wire logic [15:0] default_current, // Configured default current
  input wire logic flash_done, // Pulse: flash write finished
  input wire logic flash_ok, // Flash write result, with flash_done
  output logic motor_current_on, // Motor current applied
  output logic [15:0] motor_current_setting, // Current in use
  output logic move_start, // Pulse: start move
  output smc_pkg::smc_move_type move_kind, // Kind of move started
  output logic move_dir_ccw, // Move direction
  output logic [31:0] move_target, // Target or distance
  output logic [31:0] move_speed, // Speed
  output logic [15:0] move_accel, // Acceleration
  output logic [15:0] move_decel, // Deceleration
  output logic [15:0] move_jerk, // Jerk
  output logic [15:0] move_dwell, // Dwell time
  output logic hold_req, // Pulse: hold running move
  output logic resume_req, // Pulse: resume held move
  output logic move_held, // A held move is resumable
  output logic index_pending, // Move waits for start input
  output logic preset_load, // Pulse: load motor position
  output logic [31:0] preset_value, // Motor position to load
  output logic clear_move_complete, // Pulse: clear move-complete
  output logic clear_position_invalid, // Pulse: clear position-invalid
  output logic encoder_preset, // Pulse: preset encoder
  output logic home_gated, // Home input after gating
  output logic flash_write, // Pulse: start flash write
  output logic flash_offset, // Flash write holds encoder offset
  output logic offset_stored_ack, // Offset stored without error
  output logic err_led_green, // Error LED green
  output logic locked, // Awaiting power cycle
  output logic param_error, // Command refused for bad parameter
  output logic reserved_error // Reserved option bit seen set
);

  // ========================================================================
  // Functions
  function automatic logic pos_in_range(input logic [31:0] p);
    pos_in_range = ($signed(p) >= smc_pkg::POS_MIN) && ($signed(p) <= smc_pkg::POS_MAX);
  endfunction

  function automatic logic rate_ok(input logic [15:0] r);
    rate_ok = (r >= smc_pkg::RATE_MIN) && (r <= smc_pkg::RATE_MAX);
  endfunction

  function automatic logic motion_ok(input logic [31:0] s, input logic [15:0] a, input logic [15:0] d,
                                     input logic [15:0] j, input logic [15:0] c, input logic use_c);
    motion_ok = (s <= smc_pkg::SPEED_MAX) && rate_ok(a) && rate_ok(d) && (j <= smc_pkg::RATE_MAX) &&
                (!use_c || (c <= smc_pkg::CURRENT_MAX));
  endfunction

  // ========================================================================
  // Parameter store
  smc_param_if prm ();

  smc_param_store u_store (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .prm(prm)
  );

  assign prm.raw.position = target_position;
  assign prm.raw.speed = programmed_speed;
  assign prm.raw.accel = accel_rate;
  assign prm.raw.decel = decel_rate;
  assign prm.raw.current = drive_amps_setting;
  assign prm.raw.jerk = accel_jerk;
  assign prm.raw.dwell = dwell_time;

  assign move_target = prm.held.position;
  assign move_speed = prm.held.speed;
  assign move_accel = prm.held.accel;
  assign move_decel = prm.held.decel;
  assign move_jerk = prm.held.jerk;
  assign move_dwell = prm.held.dwell;

  // ========================================================================
  // Edge detection
  smc_pkg::smc_state_type state_q;
  logic [15:0] req_prev_q;
  logic [15:0] opt_q;
  logic start_prev_q;
  logic [15:0] rise;
  logic asm_fall;
  logic opt_cur_rise;
  logic live;
  logic move_edge;
  logic move_params_ok;
  logic start_rise;

  assign live = (state_q == smc_pkg::ST_IDLE) || (state_q == smc_pkg::ST_ARMED);
  assign rise = (image_valid && live) ? (command_request_word & ~req_prev_q) : 16'h0000; // (R23)
  assign asm_fall = image_valid && live && req_prev_q[smc_pkg::REQ_PROGRAM_ASM] &&
                    !command_request_word[smc_pkg::REQ_PROGRAM_ASM];
  assign opt_cur_rise = image_valid && live && command_option_word[smc_pkg::OPT_CURRENT_SEL] &&
                        !opt_q[smc_pkg::OPT_CURRENT_SEL];
  assign move_edge = rise[smc_pkg::REQ_ABSOLUTE] | rise[smc_pkg::REQ_RELATIVE] | rise[smc_pkg::REQ_JOG_CW] |
                     rise[smc_pkg::REQ_JOG_CCW] | rise[smc_pkg::REQ_RUN_ASM];
  assign start_rise = start_in && !start_prev_q;

  // Only words a command uses are checked; the rest may hold anything
  always_comb begin
    move_params_ok = 1'b1; // (R22)
    if (rise[smc_pkg::REQ_ABSOLUTE] || rise[smc_pkg::REQ_RELATIVE]) begin
      move_params_ok = pos_in_range(target_position) && // (R17) (R18)
                       motion_ok(programmed_speed, accel_rate, decel_rate, accel_jerk, drive_amps_setting,
                                 command_option_word[smc_pkg::OPT_CURRENT_SEL]);
    end else if (rise[smc_pkg::REQ_JOG_CW] || rise[smc_pkg::REQ_JOG_CCW]) begin
      move_params_ok = motion_ok(programmed_speed, accel_rate, decel_rate, 16'h0000, 16'h0000, 1'b0);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_prev_q <= 16'h0000;
      opt_q <= 16'h0000;
    end else if (image_valid) begin
      req_prev_q <= command_request_word;
      opt_q <= command_option_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_in;
    end
  end

  // ========================================================================
  // Driver enable, home gate, reserved bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      motor_current_on <= 1'b0;
      home_gated <= 1'b0;
      reserved_error <= 1'b0;
    end else begin
      motor_current_on <= opt_q[smc_pkg::OPT_DRIVER_ENABLE] && !config_error; // (R1)
      home_gated <= home_in && (!use_prox_gate || opt_q[smc_pkg::OPT_PROX_GATE]); // (R5)
      if (image_valid && ((command_option_word & smc_pkg::OPT_RESERVED_MASK) != 16'h0000)) begin
        reserved_error <= 1'b1;
      end else if (rise != 16'h0000) begin
        reserved_error <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Move kind, direction, capture strobes
  logic launch_now;
  logic arm_now;

  assign launch_now = move_edge && move_params_ok && !command_option_word[smc_pkg::OPT_INDEXED];
  assign arm_now = move_edge && move_params_ok && command_option_word[smc_pkg::OPT_INDEXED]; // (R9)
  assign prm.cap_all = (move_edge && move_params_ok) || (rise[smc_pkg::REQ_RESUME] && move_held); // (R27)
  assign prm.cap_target = (rise[smc_pkg::REQ_ABSOLUTE] || rise[smc_pkg::REQ_RELATIVE]) && move_params_ok;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      move_kind <= smc_pkg::MV_NONE;
      move_dir_ccw <= 1'b0;
    end else if (move_edge && move_params_ok) begin
      if (rise[smc_pkg::REQ_ABSOLUTE]) begin
        move_kind <= smc_pkg::MV_ABSOLUTE; // (R17)
        move_dir_ccw <= 1'b0;
      end else if (rise[smc_pkg::REQ_RELATIVE]) begin
        move_kind <= smc_pkg::MV_RELATIVE; // (R18)
        move_dir_ccw <= 1'b0;
      end else if (rise[smc_pkg::REQ_RUN_ASM]) begin // (R25)
        if (command_option_word[smc_pkg::OPT_DWELL]) begin
          move_kind <= smc_pkg::MV_DWELL; // (R6) (R7)
          move_dir_ccw <= 1'b0;
        end else begin
          move_kind <= smc_pkg::MV_BLEND; // (R6)
          move_dir_ccw <= command_option_word[smc_pkg::OPT_BLEND_CCW]; // (R8)
        end
      end else begin
        move_kind <= command_option_word[smc_pkg::OPT_REGISTRATION] ? smc_pkg::MV_REGISTRATION :
                     smc_pkg::MV_JOG; // (R11)
        move_dir_ccw <= rise[smc_pkg::REQ_JOG_CCW];
      end
    end
  end

  // ========================================================================
  // Motor current selection
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      motor_current_setting <= 16'h0000;
    end else if (move_edge && move_params_ok) begin
      motor_current_setting <= command_option_word[smc_pkg::OPT_CURRENT_SEL] ? drive_amps_setting :
                               default_current; // (R15)
    end else if (opt_cur_rise && drive_amps_setting <= smc_pkg::CURRENT_MAX) begin
      motor_current_setting <= drive_amps_setting; // (R16)
    end
  end

  // ========================================================================
  // Start, hold, resume
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      move_start <= 1'b0;
      hold_req <= 1'b0;
      resume_req <= 1'b0;
      move_held <= 1'b0;
    end else begin
      move_start <= launch_now || (state_q == smc_pkg::ST_ARMED && start_rise && !move_edge); // (R9)
      hold_req <= rise[smc_pkg::REQ_HOLD]; // (R20) (R26)
      resume_req <= rise[smc_pkg::REQ_RESUME] && move_held; // (R21)
      if (move_edge || (rise[smc_pkg::REQ_RESUME] && move_held)) begin
        move_held <= 1'b0; // (R26)
      end else if (rise[smc_pkg::REQ_HOLD] && move_active) begin
        move_held <= 1'b1; // (R26)
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      param_error <= 1'b0;
    end else if (move_edge && !move_params_ok) begin
      param_error <= 1'b1;
    end else if (state_q == smc_pkg::ST_DIVIDE && encoder_pulses_per_turn == 16'h0000) begin
      param_error <= 1'b1;
    end else if (move_edge) begin
      param_error <= 1'b0;
    end
  end

  // ========================================================================
  // Preset position from feedback: iterative divide
  logic [47:0] quo_q;
  logic [16:0] rem_q;
  logic [5:0] div_cnt_q;
  logic neg_q;
  logic [16:0] rem_shift;
  logic rem_fits;
  logic [31:0] enc_mag;

  assign enc_mag = encoder_position[31] ? (32'h0000_0000 - encoder_position) : encoder_position;
  assign rem_shift = {rem_q[15:0], quo_q[47]};
  assign rem_fits = rem_shift >= {1'b0, encoder_pulses_per_turn};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      quo_q <= 48'h0000_0000_0000;
      rem_q <= 17'h00000;
      div_cnt_q <= 6'h00;
      neg_q <= 1'b0;
    end else if (rise[smc_pkg::REQ_PRESET_POS] && command_option_word[smc_pkg::OPT_PRESET_FEEDBACK]) begin
      quo_q <= {16'h0000, enc_mag} * {32'h0000_0000, motor_steps_per_turn}; // (R3)
      rem_q <= 17'h00000;
      div_cnt_q <= 6'h00;
      neg_q <= encoder_position[31];
    end else if (state_q == smc_pkg::ST_DIVIDE) begin
      quo_q <= {quo_q[46:0], rem_fits};
      rem_q <= rem_fits ? (rem_shift - {1'b0, encoder_pulses_per_turn}) : rem_shift;
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      preset_load <= 1'b0;
      preset_value <= 32'h0000_0000;
    end else if (rise[smc_pkg::REQ_PRESET_POS] && !command_option_word[smc_pkg::OPT_PRESET_FEEDBACK]) begin
      preset_load <= 1'b1; // (R3)
      preset_value <= target_position;
    end else if (state_q == smc_pkg::ST_DIVIDE && div_cnt_q == 6'(smc_pkg::DIV_STEPS - 1) &&
                 encoder_pulses_per_turn != 16'h0000) begin
      preset_load <= 1'b1; // (R3)
      preset_value <= neg_q ? (32'h0000_0000 - {quo_q[30:0], rem_fits}) : {quo_q[30:0], rem_fits};
    end else begin
      preset_load <= 1'b0;
    end
  end

  assign clear_move_complete = preset_load; // (R4)
  assign clear_position_invalid = preset_load; // (R4)

  // ========================================================================
  // Flash writes and encoder preset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      encoder_preset <= 1'b0;
      flash_write <= 1'b0;
      flash_offset <= 1'b0;
    end else begin
      encoder_preset <= rise[smc_pkg::REQ_PRESET_ENC];
      flash_write <= (asm_fall || rise[smc_pkg::REQ_PRESET_ENC]) &&
                     command_option_word[smc_pkg::OPT_PERSIST]; // (R12) (R14)
      if (rise[smc_pkg::REQ_PRESET_ENC]) begin
        flash_offset <= 1'b1;
      end else if (asm_fall) begin
        flash_offset <= 1'b0;
      end
    end
  end

  // Set wins over clear on a new encoder preset edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      offset_stored_ack <= 1'b0;
    end else if (state_q == smc_pkg::ST_FLASH && flash_done && flash_ok && flash_offset) begin
      offset_stored_ack <= 1'b1; // (R14)
    end else if (rise[smc_pkg::REQ_PRESET_ENC]) begin
      offset_stored_ack <= 1'b0;
    end
  end

  // ========================================================================
  // Control state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= smc_pkg::ST_IDLE;
    end else begin
      case (state_q)
        smc_pkg::ST_IDLE, smc_pkg::ST_ARMED: begin
          if ((asm_fall || rise[smc_pkg::REQ_PRESET_ENC]) && command_option_word[smc_pkg::OPT_PERSIST]) begin
            state_q <= smc_pkg::ST_FLASH;
          end else if (rise[smc_pkg::REQ_PRESET_POS] && command_option_word[smc_pkg::OPT_PRESET_FEEDBACK]) begin
            state_q <= smc_pkg::ST_DIVIDE;
          end else if (arm_now) begin
            state_q <= smc_pkg::ST_ARMED; // (R9) (R10)
          end else if (move_edge || (state_q == smc_pkg::ST_ARMED && start_rise)) begin
            state_q <= smc_pkg::ST_IDLE;
          end
        end
        smc_pkg::ST_DIVIDE: begin
          if (div_cnt_q == 6'(smc_pkg::DIV_STEPS - 1) || encoder_pulses_per_turn == 16'h0000) begin
            state_q <= smc_pkg::ST_IDLE;
          end
        end
        smc_pkg::ST_FLASH: begin
          if (flash_done) begin
            state_q <= flash_offset ? smc_pkg::ST_IDLE : smc_pkg::ST_LOCKED; // (R13)
          end
        end
        smc_pkg::ST_LOCKED: begin
          state_q <= smc_pkg::ST_LOCKED; // (R13)
        end
        default: begin
          state_q <= smc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign index_pending = (state_q == smc_pkg::ST_ARMED);
  assign locked = (state_q == smc_pkg::ST_LOCKED);

  // ========================================================================
  // LED blink divider: enable pulse each half period
  logic [25:0] blink_cnt_q;
  logic result_ok_q;
  logic blink_tick;
  logic [25:0] half_limit;

  assign half_limit = result_ok_q ? 26'(FAST_HALF_CYCLES - 1) : 26'(SLOW_HALF_CYCLES - 1);
  assign blink_tick = locked && (blink_cnt_q == half_limit);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_ok_q <= 1'b0;
    end else if (state_q == smc_pkg::ST_FLASH && flash_done) begin
      result_ok_q <= flash_ok;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      blink_cnt_q <= 26'h0000000;
      err_led_green <= 1'b0;
    end else if (locked) begin
      blink_cnt_q <= blink_tick ? 26'h0000000 : blink_cnt_q + 26'h0000001;
      if (blink_tick) begin
        err_led_green <= !err_led_green; // (R13)
      end
    end
  end

endmodule // smc_decoder

/* test/smc_master_model.sv */
// Partner model: fieldbus master writing output images
`timescale 1ns/1ps
module smc_master_model (
  input wire logic core_clk, // Clock
  output logic image_valid, // Image strobe
  output logic [15:0] req, opt, // Command words
  output logic [31:0] pos // Position word
);
  initial {image_valid, req, opt, pos} = '0;
  // One update per call; reserved option bits kept at zero
  task automatic send(input logic [15:0] r, input logic [15:0] o, input logic [31:0] p);
    @(negedge core_clk);
    {req, opt, pos, image_valid} = {r, o & ~smc_pkg::OPT_RESERVED_MASK, p, 1'b1};
    @(negedge core_clk);
    image_valid = 1'b0;
  endtask
endmodule // smc_master_model

/* test/smc_decoder_chk.sv */
// Checker: port properties of the command decoder
`timescale 1ns/1ps
module smc_decoder_chk (
  input wire logic core_clk, rst_n, image_valid, config_error, motor_current_on, move_start, locked, // Control
  input wire logic index_pending, preset_load, clear_move_complete, clear_position_invalid, flash_write, // Flags
  input wire logic [15:0] command_request_word, dwell_time, move_dwell, // Words
  input wire smc_pkg::smc_move_type move_kind // Kind
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ====================
  // Properties
  drv_refused_a: assert property (config_error |=> !motor_current_on) else $error("current on");
  preset_clear_a: assert property (preset_load |-> clear_move_complete && clear_position_invalid)
    else $error("flags kept");
  abs_kind_a: assert property ($past(image_valid) && $past(command_request_word) == 16'h1 && move_start
    |-> move_kind == smc_pkg::MV_ABSOLUTE) else $error("kind");
  dwell_word_a: assert property (move_start && move_kind == smc_pkg::MV_DWELL |-> move_dwell == dwell_time)
    else $error("dwell");
  hold_still_a: assert property ($past(image_valid) && $past(command_request_word) == 16'h4
    && !$past(index_pending) |-> !move_start) else $error("hold start");
  start_pulse_a: assert property (move_start |=> !move_start) else $error("long start");
  lock_keep_a: assert property (locked |=> locked) else $error("unlock");
  lock_quiet_a: assert property (locked |-> !move_start && !flash_write) else $error("busy");
  cover property (move_start);
  cover property (preset_load);
  cover property (locked);
endmodule // smc_decoder_chk
bind smc_decoder smc_decoder_chk smc_decoder_chk_i (.*);

/* test/smc_decoder_tb_top.sv */
// Testbench: command sequences for the decoder
`timescale 1ns/1ps
module smc_decoder_tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, config_error = 1'b0, start_in = 1'b0, move_active = 1'b0;
  logic flash_done = 1'b0, use_prox_gate = 1'b0, home_in = 1'b0, flash_ok = 1'b1, image_valid;
  logic [15:0] command_request_word, command_option_word, accel_rate = 16'hA, decel_rate = 16'hA;
  logic [15:0] drive_amps_setting = 16'h14, accel_jerk = 16'h0, dwell_time = 16'h64, default_current = 16'h10;
  logic [15:0] motor_steps_per_turn = 16'hC8, encoder_pulses_per_turn = 16'h64, motor_current_setting;
  logic [15:0] move_accel, move_decel, move_jerk, move_dwell;
  logic [31:0] target_position, programmed_speed = 32'h3E8, encoder_position = 32'hA, move_target;
  logic [31:0] move_speed, preset_value;
  logic motor_current_on, move_start, move_dir_ccw, hold_req, resume_req, move_held, index_pending;
  logic preset_load, clear_move_complete, clear_position_invalid, encoder_preset, home_gated, flash_write;
  logic flash_offset, offset_stored_ack, err_led_green, locked, param_error, reserved_error;
  smc_pkg::smc_move_type move_kind;
  int err_total = 0, n_tests = 0;
  always #4 core_clk = ~core_clk;
  smc_master_model smc_master_model_i (.core_clk(core_clk), .image_valid(image_valid),
    .req(command_request_word), .opt(command_option_word), .pos(target_position));
  smc_decoder #(.FAST_HALF_CYCLES(4), .SLOW_HALF_CYCLES(8)) smc_decoder_i (.*);
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Zero update first so the request bit rises
  task automatic cmd(input logic [15:0] r, input logic [15:0] o, input logic [31:0] p);
    smc_master_model_i.send(16'h0, o, p);
    smc_master_model_i.send(r, o, p);
  endtask
  task automatic finish_test();
    $display("checks %0d bad %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    {rst_n, use_prox_gate, home_in} = 3'b111;
    cmd(16'h2, 16'h8002, 32'h80_0000);
    chk({move_start, param_error, home_gated}, 3'b010);
    cmd(16'h1, 16'h8000, 32'hFF80_0000);
    chk({move_start, move_kind, move_target}, {1'b1, smc_pkg::MV_ABSOLUTE, 32'hFF80_0000});
    chk({motor_current_on, motor_current_setting}, 17'h1_0010);
    $display("end moves");
    move_active = 1'b1;
    cmd(16'h4, 16'h8002, 32'h1234);
    chk({hold_req, move_held, move_start, motor_current_setting}, 19'h6_0014);
    cmd(16'h8, 16'h8002, 32'h5678);
    chk({resume_req, move_target}, {1'b1, 32'hFF80_0000});
    $display("end hold");
    cmd(16'h200, 16'h8000, 32'h37);
    chk({preset_load, clear_move_complete, clear_position_invalid, preset_value}, {3'b111, 32'h37});
    cmd(16'h200, 16'hA000, 32'h37);
    repeat (60) if (preset_load !== 1'b1) @(negedge core_clk);
    chk({preset_load, preset_value}, {1'b1, 32'h14});
    $display("end preset");
    cmd(16'h80, 16'h8880, 32'h0);
    chk({move_start, move_kind, home_gated}, {1'b1, smc_pkg::MV_REGISTRATION, 1'b1});
    cmd(16'h1, 16'h8100, 32'h10);
    chk({move_start, index_pending}, 2'b01);
    start_in = 1'b1;
    repeat (4) if (move_start !== 1'b1) @(negedge core_clk);
    chk({move_start, move_target}, {1'b1, 32'h10});
    cmd(16'h2000, 16'h8210, 32'h0);
    chk({move_kind, move_dwell}, {smc_pkg::MV_DWELL, 16'h64});
    cmd(16'h2000, 16'h8010, 32'h0);
    chk({move_kind, move_dir_ccw}, {smc_pkg::MV_BLEND, 1'b1});
    $display("end kinds");
    cmd(16'h4000, 16'h8020, 32'h0);
    chk({encoder_preset, flash_write, flash_offset}, 3'b111);
    flash_done = 1'b1;
    @(negedge core_clk);
    flash_done = 1'b0;
    chk(offset_stored_ack, 1'b1);
    config_error = 1'b1;
    cmd(16'h1000, 16'h8020, 32'h0);
    chk(motor_current_on, 1'b0);
    smc_master_model_i.send(16'h0, 16'h8020, 32'h0);
    chk(flash_write, 1'b1);
    flash_done = 1'b1;
    @(negedge core_clk);
    flash_done = 1'b0;
    cmd(16'h1, 16'h8000, 32'h0);
    chk({locked, move_start, err_led_green}, 3'b101);
    $display("end flash");
    finish_test();
  end
endmodule // smc_decoder_tb_top
